// file: design/rtc_pkg.sv
// Shared constants of the slow-clock and real-time clock block.
// Assumes a 10 MHz system clock and APB register access with 12-bit byte addresses.
package rtc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_SEC = 10'h010;
  localparam logic [9:0] IDX_YEAR = 10'h019;
  localparam logic [9:0] IDX_CTRL_A = 10'h01a;
  localparam logic [9:0] IDX_CTRL_B = 10'h01b;
  localparam logic [9:0] IDX_CTRL_C = 10'h01c;
  localparam logic [9:0] IDX_CTRL_D = 10'h01d;
  localparam logic [9:0] IDX_CAL = 10'h01e;
  localparam logic [9:0] IDX_CLK_STAT = 10'h01f;
  localparam logic [9:0] IDX_DRIVE = 10'h1c0;
  // Slots of the time array, counted from the seconds register
  localparam int SLOT_SEC = 0;
  localparam int SLOT_SEC_ALM = 1;
  localparam int SLOT_MIN = 2;
  localparam int SLOT_MIN_ALM = 3;
  localparam int SLOT_HOUR = 4;
  localparam int SLOT_HOUR_ALM = 5;
  localparam int SLOT_DOW = 6;
  localparam int SLOT_DOM = 7;
  localparam int SLOT_MONTH = 8;
  localparam int SLOT_YEAR = 9;
  localparam int NUM_SLOTS = 10;
  // Field positions
  localparam int A_UIP = 7;
  localparam int B_SET = 7;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int B_DM = 2;
  localparam int B_24H = 1;
  localparam int C_IRQF = 7;
  localparam int C_AF = 5;
  localparam int C_UF = 4;
  localparam int D_VRT = 7;
  localparam int HOUR_PM = 7;
  localparam int STAT_DIS = 0;
  localparam int STAT_INT = 7;
  localparam int DRV_SLOW = 0;
  localparam int DRV_AUDIO = 2;
  // Reset values: BCD, 24-hour; 00:00:00 Sunday 1 January 2000
  localparam logic [7:0] CTRL_B_RST = 8'h02;
  localparam logic [7:0] DRIVE_RST = 8'h04;
  localparam logic [7:0] CAL_RST = 8'h00;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] ONE_RST = 8'h01;
  // Calendar limits in plain binary
  localparam logic [6:0] SEC_LAST = 7'd59;
  localparam logic [6:0] HR24_LAST = 7'd23;
  localparam logic [6:0] HR12_LAST = 7'd12;
  localparam logic [6:0] HR12_NOON = 7'd11;
  localparam logic [6:0] DOW_LAST = 7'd7;
  localparam logic [6:0] MONTH_LAST = 7'd12;
  localparam logic [6:0] YEAR_LAST = 7'd99;
  localparam logic [6:0] FEB = 7'd2;
  localparam logic [6:0] DAYS_31 = 7'd31;
  localparam logic [6:0] DAYS_30 = 7'd30;
  localparam logic [6:0] DAYS_29 = 7'd29;
  localparam logic [6:0] DAYS_28 = 7'd28;
  // 15-bit divider: 32768 slow cycles make one second
  localparam logic [14:0] DIV_LAST = 15'h7fff;
  // Update-in-progress window: last 8 slow cycles of the second
  localparam logic [11:0] UIP_TOP = 12'hfff;
endpackage

// file: design/rtc_clk_if.sv
// Carries the slow time base between the oscillator switch, the divider and the core.
// Assumes all three modules run on the same system clock.
`timescale 1ns/100ps
interface rtc_clk_if;
  logic slow_en;      // One-cycle pulse per slow clock rising edge
  logic slow_lvl;     // Selected slow clock level
  logic int_sel;      // Internal oscillator selected
  logic [7:0] cal;    // Divider reload trim
  logic sec_tick;     // One-cycle pulse once per second
  logic near_end;     // Divider is in its last slow cycles
  modport osc (output slow_en, slow_lvl, int_sel);
  modport div (input slow_en, cal, output sec_tick, near_end);
  modport core (input slow_lvl, int_sel, sec_tick, near_end, output cal);
endinterface

// file: design/rtc_osc_switch.sv
// Glitch-free choice between crystal and internal slow oscillators.
// Assumes both oscillator levels and the crystal-running flag arrive unsynchronised.
`timescale 1ns/100ps
module rtc_osc_switch (
  input wire logic sys_clk_i,        // System clock
  input wire logic nrst_i,           // Backup reset, active low
  input wire logic xtal_clk_i,       // Crystal slow clock level
  input wire logic rc_clk_i,         // Internal oscillator level
  input wire logic xtal_running_i,   // Crystal oscillator is running
  rtc_clk_if.osc clk_if              // Slow time base out
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic sel_int_reg;
  logic lvl_reg;
  logic lvl_prev_reg;
  logic en_reg;
  logic xtal_lo;
  logic rc_lo;

  // Two-flop synchronisers for the three asynchronous inputs
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= (g == 0) ? xtal_clk_i : (g == 1) ? rc_clk_i : xtal_running_i;
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign xtal_lo = ~sync_reg[0];
  assign rc_lo = ~sync_reg[1];

  // switch only when both low
  // Starts on the internal oscillator since the crystal is not yet proven
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_int_reg <= 1'b1;
    end else if ((sel_int_reg == sync_reg[2]) && xtal_lo && rc_lo) begin
      sel_int_reg <= ~sync_reg[2];
    end
  end

  // Selected level and its rising-edge enable
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_reg <= 1'b0;
      lvl_prev_reg <= 1'b0;
      en_reg <= 1'b0;
    end else begin
      lvl_reg <= sel_int_reg ? sync_reg[1] : sync_reg[0];
      lvl_prev_reg <= lvl_reg;
      en_reg <= lvl_reg & ~lvl_prev_reg;
    end
  end

  assign clk_if.slow_en = en_reg;
  assign clk_if.slow_lvl = lvl_reg;
  assign clk_if.int_sel = sel_int_reg;
endmodule

// file: design/rtc_sec_divider.sv
// 15-bit divider turning slow clock edges into a once-per-second pulse.
// Assumes one slow-edge enable pulse per slow cycle from the oscillator switch.
`timescale 1ns/100ps
module rtc_sec_divider (
  input wire logic sys_clk_i,   // System clock
  input wire logic nrst_i,      // Backup reset, active low
  rtc_clk_if.div clk_if         // Slow enable in, second tick out
);
  logic [14:0] cnt_reg;
  logic tick_reg;

  // calibration reload trim
  // Reloading with the trim shortens each second by that many slow cycles
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 15'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (clk_if.slow_en) begin
        if (cnt_reg == rtc_pkg::DIV_LAST) begin
          cnt_reg <= {7'h00, clk_if.cal};
          tick_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 15'h0001;
        end
      end
    end
  end

  assign clk_if.sec_tick = tick_reg;
  assign clk_if.near_end = (cnt_reg[14:3] == rtc_pkg::UIP_TOP);
endmodule

// file: design/rtc_core.sv
// Real-time clock core: APB registers, calendar counting, alarm and clock outputs.
// Assumes an APB master on sys_clk_i and oscillator pins not synchronised to it.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

// Functional notes
// - Fall back to internal oscillator without crystal
// - Switch sources only while both low
// - Status bit shows internal oscillator selected
// - Startup sequencer enables slow clock output
// - Output disable bit resets to zero
// - Two-bit slow clock drive strength
// - Two-bit audio clock drive strength
// - Audio clock only with 3.3 V rail
// - Fifteen-bit divider makes 1 Hz tick
// - Calibration trims the second divider
// - Seven time and calendar counters
// - Alarm registers raise alarm interrupt
// - Binary or BCD eight-bit values
// - Twelve or twenty-four hour format
// - Register B sets format and masks
// - Registers A, C, D report status
// - Reset loads midnight 1 January 2000
// - February has 29 days in leap years
// - Month end rolls to day one
// - Separate mask and flag per interrupt
// - Sixteen bytes of RTC registers
// - Alarm compared once per second
// - Set bit freezes all updates
// - Hour bit seven marks PM
module rtc_core (
  input wire logic sys_clk_i,          // 10 MHz system clock
  input wire logic nrst_i,             // Backup power-on reset, active low
  input wire logic psel,               // APB select
  input wire logic penable,            // APB access phase
  input wire logic pwrite,             // APB write
  input wire logic [11:0] paddr,       // APB byte address
  input wire logic [31:0] pwdata,      // APB write data
  output logic [31:0] prdata,          // APB read data
  output logic pready,                 // APB ready
  output logic pslverr,                // APB error on unmapped address
  input wire logic xtal_clk_i,         // Crystal slow clock level
  input wire logic rc_clk_i,           // Internal oscillator level
  input wire logic xtal_running_i,     // Crystal oscillator running
  input wire logic startup_en_i,       // Startup sequencer output enable
  input wire logic switched_3v3_rail_i, // Switched 3.3 V rail enabled
  output logic slow_clock_out_o,       // Slow clock output pin level
  output logic audio_clock_out_en_o,   // Gate enable for audio clock pin
  output logic [1:0] slow_clock_drive_strength_o,  // Slow pin drive
  output logic [1:0] audio_clock_drive_strength_o, // Audio pin drive
  output logic rtc_irq_o               // Alarm or update interrupt
);
  rtc_clk_if clk_if ();

  logic [7:0] tm_reg [rtc_pkg::NUM_SLOTS];
  logic [7:0] tm_next [rtc_pkg::NUM_SLOTS];
  logic [7:0] ctrl_b_reg;
  logic uip_reg;
  logic af_reg;
  logic uf_reg;
  logic irq_reg;
  logic vrt_reg;
  logic [7:0] cal_reg;
  logic [7:0] drive_reg;
  logic slow_dis_reg;
  logic alarm_chk_reg;
  logic [31:0] rdata_reg;
  logic ready_reg;
  logic err_reg;
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic slow_out_reg;
  logic audio_en_reg;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_en;
  logic [9:0] idx;
  logic idx_time;
  logic mapped;
  logic bcd;
  logic do_update;
  logic [3:0] slot;

  rtc_osc_switch u_osc (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .xtal_clk_i(xtal_clk_i),
    .rc_clk_i(rc_clk_i),
    .xtal_running_i(xtal_running_i),
    .clk_if(clk_if.osc)
  );

  rtc_sec_divider u_div (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clk_if(clk_if.div)
  );

  assign clk_if.cal = cal_reg;

  // Value format helpers; BCD when the format bit is clear
  function automatic logic [7:0] to_fmt(input logic [6:0] b, input logic in_bcd);
    logic [6:0] t;
    logic [6:0] o;
    t = b / 7'd10;
    o = b % 7'd10;
    return in_bcd ? {t[3:0], o[3:0]} : {1'b0, b};
  endfunction

  function automatic logic [6:0] from_fmt(input logic [7:0] v, input logic in_bcd);
    logic [6:0] t;
    t = {3'h0, v[7:4]};
    return in_bcd ? 7'(t * 7'd10 + {3'h0, v[3:0]}) : v[6:0];
  endfunction

  function automatic logic [7:0] inc_fmt(input logic [7:0] v, input logic in_bcd);
    if (in_bcd && (v[3:0] == 4'h9)) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end
    return 8'(v + 8'h01);
  endfunction

  assign bcd = ~ctrl_b_reg[rtc_pkg::B_DM];
  assign do_update = clk_if.sec_tick & ~ctrl_b_reg[rtc_pkg::B_SET];

  always_comb begin
    logic c;
    logic pm;
    logic [7:0] hv;
    logic [6:0] dim;
    logic [6:0] mon_b;
    c = 1'b1;
    pm = tm_reg[rtc_pkg::SLOT_HOUR][rtc_pkg::HOUR_PM];
    hv = {1'b0, tm_reg[rtc_pkg::SLOT_HOUR][6:0]};
    dim = rtc_pkg::DAYS_31;
    mon_b = from_fmt(tm_reg[rtc_pkg::SLOT_MONTH], bcd);
    for (int i = 0; i < rtc_pkg::NUM_SLOTS; i++) begin
      tm_next[i] = tm_reg[i];
    end
    if (tm_reg[rtc_pkg::SLOT_SEC] == to_fmt(rtc_pkg::SEC_LAST, bcd)) begin
      tm_next[rtc_pkg::SLOT_SEC] = rtc_pkg::ZERO_RST;
    end else begin
      tm_next[rtc_pkg::SLOT_SEC] = inc_fmt(tm_reg[rtc_pkg::SLOT_SEC], bcd);
      c = 1'b0;
    end
    if (c) begin
      if (tm_reg[rtc_pkg::SLOT_MIN] == to_fmt(rtc_pkg::SEC_LAST, bcd)) begin
        tm_next[rtc_pkg::SLOT_MIN] = rtc_pkg::ZERO_RST;
      end else begin
        tm_next[rtc_pkg::SLOT_MIN] = inc_fmt(tm_reg[rtc_pkg::SLOT_MIN], bcd);
        c = 1'b0;
      end
    end
    if (c) begin
      if (ctrl_b_reg[rtc_pkg::B_24H]) begin
        if (tm_reg[rtc_pkg::SLOT_HOUR] == to_fmt(rtc_pkg::HR24_LAST, bcd)) begin
          tm_next[rtc_pkg::SLOT_HOUR] = rtc_pkg::ZERO_RST;
        end else begin
          tm_next[rtc_pkg::SLOT_HOUR] = inc_fmt(tm_reg[rtc_pkg::SLOT_HOUR], bcd);
          c = 1'b0;
        end
      end else begin
        if (hv == to_fmt(rtc_pkg::HR12_LAST, bcd)) begin
          tm_next[rtc_pkg::SLOT_HOUR] = {pm, 7'(to_fmt(7'd1, bcd))};
          c = 1'b0;
        end else if (hv == to_fmt(rtc_pkg::HR12_NOON, bcd)) begin
          tm_next[rtc_pkg::SLOT_HOUR] = {~pm, 7'(to_fmt(rtc_pkg::HR12_LAST, bcd))};
          c = pm;
        end else begin
          tm_next[rtc_pkg::SLOT_HOUR] = {pm, 7'(inc_fmt(hv, bcd))};
          c = 1'b0;
        end
      end
    end
    // leap February
    // Years 00 to 99 stand for 2000 to 2099, so every fourth year is leap
    if (mon_b == rtc_pkg::FEB) begin
      dim = (from_fmt(tm_reg[rtc_pkg::SLOT_YEAR], bcd) % 7'd4 == 7'd0) ?
            rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
    end else if ((mon_b == 7'd4) || (mon_b == 7'd6) || (mon_b == 7'd9) ||
                 (mon_b == 7'd11)) begin
      dim = rtc_pkg::DAYS_30;
    end
    if (c) begin
      if (tm_reg[rtc_pkg::SLOT_DOW] == to_fmt(rtc_pkg::DOW_LAST, bcd)) begin
        tm_next[rtc_pkg::SLOT_DOW] = rtc_pkg::ONE_RST;
      end else begin
        tm_next[rtc_pkg::SLOT_DOW] = inc_fmt(tm_reg[rtc_pkg::SLOT_DOW], bcd);
      end
      if (tm_reg[rtc_pkg::SLOT_DOM] == to_fmt(dim, bcd)) begin
        tm_next[rtc_pkg::SLOT_DOM] = rtc_pkg::ONE_RST;
      end else begin
        tm_next[rtc_pkg::SLOT_DOM] = inc_fmt(tm_reg[rtc_pkg::SLOT_DOM], bcd);
        c = 1'b0;
      end
    end
    if (c) begin
      if (tm_reg[rtc_pkg::SLOT_MONTH] == to_fmt(rtc_pkg::MONTH_LAST, bcd)) begin
        tm_next[rtc_pkg::SLOT_MONTH] = rtc_pkg::ONE_RST;
      end else begin
        tm_next[rtc_pkg::SLOT_MONTH] = inc_fmt(tm_reg[rtc_pkg::SLOT_MONTH], bcd);
        c = 1'b0;
      end
    end
    if (c) begin
      if (tm_reg[rtc_pkg::SLOT_YEAR] == to_fmt(rtc_pkg::YEAR_LAST, bcd)) begin
        tm_next[rtc_pkg::SLOT_YEAR] = rtc_pkg::ZERO_RST;
      end else begin
        tm_next[rtc_pkg::SLOT_YEAR] = inc_fmt(tm_reg[rtc_pkg::SLOT_YEAR], bcd);
      end
    end
  end

  // APB decode; a transfer completes at the first access-phase edge
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & ready_reg;
  assign wr_en = access_ph & pwrite & ~err_reg;
  assign rd_en = access_ph & ~pwrite & ~err_reg;
  assign idx = paddr[11:2];
  assign idx_time = (idx >= rtc_pkg::IDX_SEC) && (idx <= rtc_pkg::IDX_YEAR);
  assign slot = 4'(idx - rtc_pkg::IDX_SEC);
  // sixteen mapped RTC bytes plus drive register
  assign mapped = (paddr[1:0] == 2'b00) &&
                  ((idx >= rtc_pkg::IDX_SEC && idx <= rtc_pkg::IDX_CLK_STAT) ||
                   idx == rtc_pkg::IDX_DRIVE);

  // reset to midnight 1 January 2000
  // Software writes win over a tick landing in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < rtc_pkg::NUM_SLOTS; i++) begin
        tm_reg[i] <= ((i == rtc_pkg::SLOT_DOW) || (i == rtc_pkg::SLOT_DOM) ||
                      (i == rtc_pkg::SLOT_MONTH)) ? rtc_pkg::ONE_RST : rtc_pkg::ZERO_RST;
      end
    end else if (wr_en && idx_time) begin
      tm_reg[slot] <= pwdata[7:0];
    end else if (do_update) begin
      tm_reg <= tm_next;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_b_reg <= rtc_pkg::CTRL_B_RST;
      cal_reg <= rtc_pkg::CAL_RST;
      drive_reg <= rtc_pkg::DRIVE_RST;
      slow_dis_reg <= 1'b0;
    end else if (wr_en) begin
      if (idx == rtc_pkg::IDX_CTRL_B) begin
        ctrl_b_reg <= pwdata[7:0];
      end
      if (idx == rtc_pkg::IDX_CAL) begin
        cal_reg <= pwdata[7:0];
      end
      if (idx == rtc_pkg::IDX_DRIVE) begin
        drive_reg <= pwdata[7:0];
      end
      if (idx == rtc_pkg::IDX_CLK_STAT) begin
        slow_dis_reg <= pwdata[rtc_pkg::STAT_DIS];
      end
    end
  end

  // alarm compare after each update
  // Comparing a cycle later sees the freshly advanced time
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alarm_chk_reg <= 1'b0;
    end else begin
      alarm_chk_reg <= do_update;
    end
  end

  // status reported in C
  // Reading C clears the flags, but an event in the same cycle still sets them
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      af_reg <= 1'b0;
      uf_reg <= 1'b0;
    end else begin
      if (alarm_chk_reg &&
          tm_reg[rtc_pkg::SLOT_SEC] == tm_reg[rtc_pkg::SLOT_SEC_ALM] &&
          tm_reg[rtc_pkg::SLOT_MIN] == tm_reg[rtc_pkg::SLOT_MIN_ALM] &&
          tm_reg[rtc_pkg::SLOT_HOUR] == tm_reg[rtc_pkg::SLOT_HOUR_ALM]) begin
        af_reg <= 1'b1;
      end else if (rd_en && idx == rtc_pkg::IDX_CTRL_C) begin
        af_reg <= 1'b0;
      end
      if (alarm_chk_reg) begin
        uf_reg <= 1'b1;
      end else if (rd_en && idx == rtc_pkg::IDX_CTRL_C) begin
        uf_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (af_reg & ctrl_b_reg[rtc_pkg::B_AIE]) |
                 (uf_reg & ctrl_b_reg[rtc_pkg::B_UIE]);
    end
  end

  // update-in-progress and valid time
  // Valid time is raised once software leaves set mode after initialising
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      uip_reg <= 1'b0;
      vrt_reg <= 1'b0;
    end else begin
      uip_reg <= clk_if.near_end & ~ctrl_b_reg[rtc_pkg::B_SET];
      if (wr_en && idx == rtc_pkg::IDX_CTRL_B && ctrl_b_reg[rtc_pkg::B_SET] &&
          !pwdata[rtc_pkg::B_SET]) begin
        vrt_reg <= 1'b1;
      end
    end
  end

  // APB answer registered in the setup cycle so outputs come from flops
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (setup_ph) begin
      ready_reg <= 1'b1;
      err_reg <= ~mapped;
      rdata_reg <= 32'h0000_0000;
      if (mapped && !pwrite) begin
        if (idx_time) begin
          rdata_reg[7:0] <= tm_reg[slot];
        end
        case (idx)
          rtc_pkg::IDX_CTRL_A: rdata_reg[rtc_pkg::A_UIP] <= uip_reg;
          rtc_pkg::IDX_CTRL_B: rdata_reg[7:0] <= ctrl_b_reg;
          rtc_pkg::IDX_CTRL_C: begin
            rdata_reg[rtc_pkg::C_IRQF] <= irq_reg;
            rdata_reg[rtc_pkg::C_AF] <= af_reg;
            rdata_reg[rtc_pkg::C_UF] <= uf_reg;
          end
          rtc_pkg::IDX_CTRL_D: rdata_reg[rtc_pkg::D_VRT] <= vrt_reg;
          rtc_pkg::IDX_CAL: rdata_reg[7:0] <= cal_reg;
          rtc_pkg::IDX_DRIVE: rdata_reg[7:0] <= drive_reg;
          rtc_pkg::IDX_CLK_STAT: begin
            rdata_reg[rtc_pkg::STAT_DIS] <= slow_dis_reg;
            rdata_reg[rtc_pkg::STAT_INT] <= clk_if.int_sel;
          end
          default: ;
        endcase
      end
    end else begin
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end
  end

  // Two-flop synchronisers for the startup enable and rail pins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_reg <= 2'b00;
      pin_sync_reg <= 2'b00;
    end else begin
      pin_meta_reg <= {switched_3v3_rail_i, startup_en_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slow_out_reg <= 1'b0;
      audio_en_reg <= 1'b0;
    end else begin
      slow_out_reg <= clk_if.slow_lvl & pin_sync_reg[0] & ~slow_dis_reg;
      audio_en_reg <= pin_sync_reg[1];
    end
  end

  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = err_reg;
  assign slow_clock_out_o = slow_out_reg;
  assign audio_clock_out_en_o = audio_en_reg;
  assign slow_clock_drive_strength_o = drive_reg[rtc_pkg::DRV_SLOW +: 2];
  assign audio_clock_drive_strength_o = drive_reg[rtc_pkg::DRV_AUDIO +: 2];
  assign rtc_irq_o = irq_reg;
endmodule

// file: sim/rtc_core_sva.sv
// Checker for the RTC core bus answer and pin gating.
// Assumes it is bound to rtc_core and sees only its ports.
`timescale 1ns/100ps
module rtc_core_sva (
  input wire logic sys_clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic startup_en_i, // Startup enable
  input wire logic switched_3v3_rail_i, // Rail on
  input wire logic slow_clock_out_o, // Slow pin
  input wire logic audio_clock_out_en_o, // Audio gate
  input wire logic [1:0] slow_clock_drive_strength_o, // Slow drive
  input wire logic [1:0] audio_clock_drive_strength_o // Audio drive
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic drv_wr;
  // Drive register written in this access
  assign drv_wr = psel && penable && pwrite && pready && paddr == 12'h700;
  ready_fast_a: assert property (psel && !penable |=> pready) else $error("late ready");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready) else $error("ready");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("err");
  byte_data_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("wide");
  // Two quiet cycles cover a possible extra output register
  drive_hold_a: assert property (!drv_wr [*2] |=> $stable({slow_clock_drive_strength_o,
    audio_clock_drive_strength_o})) else $error("drive moved");
  slow_gate_a: assert property (!startup_en_i [*4] |-> !slow_clock_out_o) else $error("slow");
  audio_off_a: assert property (!switched_3v3_rail_i [*4] |-> !audio_clock_out_en_o)
    else $error("audio on");
  audio_on_a: assert property (switched_3v3_rail_i [*4] |-> audio_clock_out_en_o)
    else $error("audio off");
  cover property (drv_wr);
  cover property (pslverr);
  cover property (slow_clock_out_o);
endmodule
bind rtc_core rtc_core_sva i_sva (.*);

// file: sim/rtc_core_tb.sv
// Self-checking bench for the RTC core through APB and its pins.
// Assumes the core is the only slave; slow clocks come from a counter.
`timescale 1ns/100ps
module rtc_core_tb;
  logic sys_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, er, hi;
  logic xtal_running_i, startup_en_i, rail, slow_o, audio_o, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] sdrv, adrv;
  logic [3:0] cnt = 4'h0;
  logic xtal_clk_i = 1'b0;
  logic rc_clk_i = 1'b0;
  int err_total, compares;
  rtc_core i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xtal_clk_i(xtal_clk_i), .rc_clk_i(rc_clk_i),
    .xtal_running_i(xtal_running_i), .startup_en_i(startup_en_i),
    .switched_3v3_rail_i(rail), .slow_clock_out_o(slow_o), .audio_clock_out_en_o(audio_o),
    .slow_clock_drive_strength_o(sdrv), .audio_clock_drive_strength_o(adrv), .rtc_irq_o(irq));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Both slow sources run fast so that one divider second fits in the run
  always @(posedge sys_clk_i) begin
    cnt <= cnt + 4'h1;
    rc_clk_i <= cnt[0];
    xtal_clk_i <= cnt[1];
  end
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk_i);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      chk("timeout", 32'h0, 32'h1);
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  // Slow pin seen high at any point in 40 cycles
  task automatic watch;
    hi = 1'b0;
    repeat (40) begin
      @(posedge sys_clk_i);
      hi = hi | slow_o;
    end
  endtask
  // Bounded wait for the interrupt pin; the first second is a full divider span
  task automatic wait_irq;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 70000) begin
      @(posedge sys_clk_i);
      i++;
    end
    if (irq !== 1'b1) begin
      chk("irq_timeout", 32'h0, 32'h1);
      end_sim();
    end
  endtask
  initial begin
    nrst_i = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {xtal_running_i, startup_en_i, rail} = 3'h0;
    repeat (6) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    rdchk(12'h040, 32'h0, "sec");
    rdchk(12'h058, 32'h1, "dow");
    rdchk(12'h05c, 32'h1, "dom");
    rdchk(12'h060, 32'h1, "month");
    rdchk(12'h06c, 32'h2, "ctrl_b");
    rdchk(12'h07c, 32'h80, "status");
    $display("Reset values done");
    // Set mode, 12-hour BCD, then leave set mode
    xfer(1'b1, 12'h06c, 32'h80);
    xfer(1'b1, 12'h050, 32'h92);
    rdchk(12'h050, 32'h92, "hour_pm");
    xfer(1'b1, 12'h06c, 32'h06);
    rdchk(12'h074, 32'h80, "ctrl_d");
    rdchk(12'h06c, 32'h06, "ctrl_b_wr");
    $display("Format done");
    // Set mode, binary 24-hour; last second of 29 February 2000
    xfer(1'b1, 12'h06c, 32'h86);
    xfer(1'b1, 12'h040, 32'h3b);
    xfer(1'b1, 12'h048, 32'h3b);
    xfer(1'b1, 12'h050, 32'h17);
    xfer(1'b1, 12'h05c, 32'h1d);
    xfer(1'b1, 12'h060, 32'h02);
    // Both interrupts unmasked; alarms still hold their reset midnight
    xfer(1'b1, 12'h06c, 32'h36);
    wait_irq();
    rdchk(12'h040, 32'h0, "sec_wrap");
    rdchk(12'h048, 32'h0, "min_wrap");
    rdchk(12'h050, 32'h0, "hour_wrap");
    rdchk(12'h058, 32'h2, "dow_step");
    rdchk(12'h05c, 32'h1, "leap_end");
    rdchk(12'h060, 32'h3, "month_step");
    rdchk(12'h064, 32'h0, "year_hold");
    rdchk(12'h070, 32'hb0, "flags");
    rdchk(12'h070, 32'h0, "flags_clear");
    chk("irq_clear", {31'h0, irq}, 32'h0);
    $display("Calendar done");
    xfer(1'b1, 12'h700, 32'h0b);
    repeat (2) @(posedge sys_clk_i);
    chk("slow_drv", {30'h0, sdrv}, 32'h3);
    chk("audio_drv", {30'h0, adrv}, 32'h2);
    xfer(1'b1, 12'h004, 32'hff);
    chk("unmapped", {31'h0, er}, 32'h1);
    $display("Drive and refusal done");
    startup_en_i <= 1'b1;
    rail <= 1'b1;
    watch();
    chk("slow_on", {31'h0, hi}, 32'h1);
    chk("audio_on", {31'h0, audio_o}, 32'h1);
    xfer(1'b1, 12'h07c, 32'h01);
    repeat (4) @(posedge sys_clk_i);
    watch();
    chk("slow_off", {31'h0, hi}, 32'h0);
    xtal_running_i <= 1'b1;
    repeat (60) @(posedge sys_clk_i);
    rdchk(12'h07c, 32'h01, "xtal_sel");
    $display("Pins done");
    end_sim();
  end
endmodule
